// ### src/lpcc_ctrl.sv
/*
  Command and control input stage: gates inputs with the clock gate,
  decodes commands under chip select, tracks open rows and power state,
  and feeds the write mask stage.
  Holds one open-row flag per bank, the registered clock gate and the
  power state, and registers each accepted command for one cycle.
  Self refresh exit follows the gate level itself, so the internal
  clocks restart in the same cycle as the gate rises.
  Assumes ref_clk_i marks the rising crossing of the input clock pair;
  strobe edges arrive as synchronous flags.
  Assumes every pin is already synchronous to ref_clk_i and that the
  controller keeps the gate high for two cycles after power-down before
  it gives the next command.
*/
`timescale 1ns/10ps
module lpcc_ctrl #(
  parameter int LANES  = 2,
  parameter bit DUAL_DIE = 1'b0
) (
  input  wire logic                    ref_clk_i,
  input  wire logic                    rst_i,
  input  wire lpcc_pkg::lpcc_cmd_pins_s pins_i,
  input  wire logic                    die1_clock_gate_i,
  input  wire logic                    die1_select_n_i,
  input  wire logic                    strobe_rise_i,
  input  wire logic                    strobe_fall_i,
  input  wire logic [8*LANES-1:0]      wdata_i,
  input  wire logic [LANES-1:0]        write_byte_mask_i,
  input  wire logic                    wr_burst_i,
  output lpcc_pkg::lpcc_cmd_s          cmd_o,
  output lpcc_pkg::lpcc_pwr_e          pwr_state_o,
  output logic                         clocks_on_o,
  output logic                         drivers_on_o,
  output logic [8*LANES-1:0]           wdata_o,
  output logic [LANES-1:0]             byte_we_o,
  output logic                         wvalid_o
);
  import lpcc_pkg::*;

  lpcc_pwr_e              state;
  lpcc_pwr_e              next_state;
  lpcc_cmd_s              cmd;
  lpcc_cmd_s              next_cmd;
  logic [NUM_BANKS-1:0]   open_rows;
  logic [NUM_BANKS-1:0]   next_open_rows;
  logic                   gate_q;
  logic                   next_gate;
  logic                   gate_pin;
  logic                   sel_n_pin;
  logic [3:0]             code;
  logic [BANK_W-1:0]      bank;
  logic                   powered_down;
  logic                   sr_exit;
  logic                   running;
  logic                   take;
  logic                   ap;
  logic                   is_act;
  logic                   is_pre;
  logic                   is_rw;
  logic [NUM_BANKS-1:0]   bank_hot;

  function automatic logic [NUM_BANKS-1:0] bank_dec(
    input logic [BANK_W-1:0] b
  );
    bank_dec = '0;
    bank_dec[b] = 1'b1;
  endfunction : bank_dec

  // Die selection for a stacked part
  assign gate_pin  = DUAL_DIE ? die1_clock_gate_i
                              : pins_i.die0_clock_gate;
  assign sel_n_pin = DUAL_DIE ? die1_select_n_i : pins_i.die0_select_n;

  assign code = {sel_n_pin, pins_i.row_strobe_n,
                 pins_i.col_strobe_n, pins_i.write_strobe_n};
  assign bank = {pins_i.bank_select_hi, pins_i.bank_select_lo};

  assign powered_down = (state == LPCC_PRE_PD) || (state == LPCC_ACT_PD)
                        || (state == LPCC_SELF_REF);
  // Self refresh leaves on the gate level itself, not the registered copy
  assign sr_exit = (state == LPCC_SELF_REF) && gate_pin;
  assign running = (state == LPCC_IDLE) || (state == LPCC_ACTIVE);

  // Command decode, only while awake, gated on and selected
  assign take     = running && gate_pin && !sel_n_pin;
  assign ap       = pins_i.addr[AP_BIT];
  assign is_act   = take && (code == CMD_ACT);
  assign is_pre   = take && (code == CMD_PRE);
  assign is_rw    = take && ((code == CMD_RD) || (code == CMD_WR));
  assign bank_hot = bank_dec(bank);

  // Open row of each bank
  generate
    for (genvar g = 0; g < NUM_BANKS; g++)
    begin : g_bank
      logic row_open;
      logic next_row_open;

      always_comb
      begin
        next_row_open = row_open;
        if (is_act && bank_hot[g])
          next_row_open = 1'b1;
        else if (is_pre && (ap || bank_hot[g]))
          next_row_open = 1'b0;
        else if (is_rw && ap && bank_hot[g])
          next_row_open = 1'b0;
      end

      always_ff @(posedge ref_clk_i)
      begin
        if (rst_i)
          row_open <= 1'b0;
        else
          row_open <= next_row_open;
      end

      assign open_rows[g]      = row_open;
      assign next_open_rows[g] = next_row_open;
    end
  endgenerate

  // Command capture
  always_comb
  begin
    next_cmd      = '0;
    next_cmd.code = CMD_NOP;
    if (take)
    begin
      next_cmd.valid = 1'b1;
      next_cmd.code  = code;
      next_cmd.bank  = bank;
      next_cmd.addr  = pins_i.addr;
      next_cmd.auto_precharge_bit = ap;
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
      cmd <= '0;
    else
      cmd <= next_cmd;
  end

  // Power state and registered clock gate
  always_comb
  begin
    next_gate  = gate_pin;
    next_state = state;
    case (state)
      LPCC_IDLE, LPCC_ACTIVE:
      begin
        if (!gate_pin)
        begin
          if (open_rows != '0)
            next_state = LPCC_ACT_PD;
          else if (code == CMD_REF)
            next_state = LPCC_SELF_REF;
          else
            next_state = LPCC_PRE_PD;
        end
        else if (next_open_rows != '0)
          next_state = LPCC_ACTIVE;
        else
          next_state = LPCC_IDLE;
      end
      LPCC_PRE_PD:
      begin
        if (gate_q)
          next_state = LPCC_IDLE;
      end
      LPCC_ACT_PD:
      begin
        if (gate_q)
          next_state = LPCC_ACTIVE;
      end
      LPCC_SELF_REF:
      begin
        if (sr_exit)
          next_state = LPCC_IDLE;
      end
      default:
        next_state = LPCC_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      state  <= LPCC_IDLE;
      gate_q <= 1'b0;
    end
    else
    begin
      state  <= next_state;
      gate_q <= next_gate;
    end
  end

  assign cmd_o        = cmd;
  assign pwr_state_o  = state;
  assign clocks_on_o  = !powered_down || sr_exit;
  assign drivers_on_o = !powered_down;

  lpcc_wmask #(
    .LANES(LANES)
  ) u_wmask (
    .ref_clk_i         (ref_clk_i),
    .rst_i             (rst_i),
    .wr_active_i       (wr_burst_i && !powered_down),
    .strobe_rise_i     (strobe_rise_i),
    .strobe_fall_i     (strobe_fall_i),
    .wdata_i           (wdata_i),
    .write_byte_mask_i (write_byte_mask_i),
    .wdata_o           (wdata_o),
    .byte_we_o         (byte_we_o),
    .wvalid_o          (wvalid_o)
  );

endmodule : lpcc_ctrl

// ### src/lpcc_pkg.sv
/*
  Package of the command and control input stage: pin groups, command
  codes, power states and field positions.
  Assumes one system clock ref_clk_i that stands in for the crossing of
  the differential input clock.
*/
// What this block does
// - Address and control inputs are captured only where the true clock rises.
// - Read and write data move on both clock crossings, two per cycle; here write data only, at most one word per ref_clk_i cycle.
// - Clock gate high keeps clocks, buffers, drivers on; low turns them off.
// - Gate low with all banks idle enters precharge power-down or self refresh.
// - Gate low with any row open enters active power-down.
// - Clock gate is registered, except self refresh exit which reacts at once.
// - In power-down and self refresh only the clock gate input is observed.
// - Commands are decoded only when chip select is sampled low.
// - Command code is select plus row, column and write strobes together.
// - Write bytes whose mask is high are discarded, storage unchanged.
// - Write mask is sampled on both strobe edges like write data.
// - Mask is input only; two lines for 16-bit, four for 32-bit.
// - Second die uses second gate and select; single die uses the first.
// - Two bank select bits pick bank, or mode register for load-mode.
// - Address bit ten requests auto precharge, or precharge of all banks.
// - Device drives strobe edge aligned on reads; controller centres it.
package lpcc_pkg;

  localparam int ADDR_W       = 14;
  localparam int AP_BIT       = 10;
  localparam int NUM_BANKS    = 4;
  localparam int BANK_W       = 2;

  // Command code {select_n, row_n, col_n, we_n}
  localparam logic [3:0] CMD_LMR  = 4'h0;
  localparam logic [3:0] CMD_REF  = 4'h1;
  localparam logic [3:0] CMD_PRE  = 4'h2;
  localparam logic [3:0] CMD_ACT  = 4'h3;
  localparam logic [3:0] CMD_WR   = 4'h4;
  localparam logic [3:0] CMD_RD   = 4'h5;
  localparam logic [3:0] CMD_BST  = 4'h6;
  localparam logic [3:0] CMD_NOP  = 4'h7;

  typedef enum logic [2:0] {
    LPCC_IDLE,
    LPCC_ACTIVE,
    LPCC_PRE_PD,
    LPCC_ACT_PD,
    LPCC_SELF_REF
  } lpcc_pwr_e;

  typedef struct packed {
    logic              die0_clock_gate;
    logic              die0_select_n;
    logic              row_strobe_n;
    logic              col_strobe_n;
    logic              write_strobe_n;
    logic              bank_select_hi;
    logic              bank_select_lo;
    logic [ADDR_W-1:0] addr;
  } lpcc_cmd_pins_s;

  typedef struct packed {
    logic              valid;
    logic [3:0]        code;
    logic [BANK_W-1:0] bank;
    logic [ADDR_W-1:0] addr;
    logic              auto_precharge_bit;
  } lpcc_cmd_s;

endpackage : lpcc_pkg

// ### src/lpcc_wmask.sv
/*
  Write data mask stage: captures data and mask on both data strobe
  edges and forms per-byte write enables.
  Assumes strobe edge flags are already synchronous to ref_clk_i.
*/
`timescale 1ns/10ps
module lpcc_wmask #(
  parameter int LANES = 2
) (
  input  wire logic                 ref_clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 wr_active_i,
  input  wire logic                 strobe_rise_i,
  input  wire logic                 strobe_fall_i,
  input  wire logic [8*LANES-1:0]   wdata_i,
  input  wire logic [LANES-1:0]     write_byte_mask_i,
  output logic      [8*LANES-1:0]   wdata_o,
  output logic      [LANES-1:0]     byte_we_o,
  output logic                      wvalid_o
);
  import lpcc_pkg::*;

  logic [8*LANES-1:0] data_q;
  logic [8*LANES-1:0] next_data;
  logic [LANES-1:0]   we_q;
  logic [LANES-1:0]   next_we;
  logic               valid_q;
  logic               next_valid;

  always_comb
  begin
    next_data  = data_q;
    next_we    = '0;
    next_valid = 1'b0;
    if (wr_active_i && (strobe_rise_i || strobe_fall_i))
    begin
      next_data  = wdata_i;
      next_we    = ~write_byte_mask_i;
      next_valid = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      data_q  <= '0;
      we_q    <= '0;
      valid_q <= 1'b0;
    end
    else
    begin
      data_q  <= next_data;
      we_q    <= next_we;
      valid_q <= next_valid;
    end
  end

  assign wdata_o   = data_q;
  assign byte_we_o = we_q;
  assign wvalid_o  = valid_q;

endmodule : lpcc_wmask

// ### verif/lpcc_ctrl_assertions.sv
/* Port checker of lpcc_ctrl.
   Assumes one clock and a synchronous reset; bound below. */
`timescale 1ns/10ps
module lpcc_ctrl_assertions
  import lpcc_pkg::*;
#(parameter int LANES = 2)
(
  input wire logic                     ref_clk_i,
  input wire logic                     rst_i,
  input wire lpcc_pkg::lpcc_cmd_pins_s pins_i,
  input wire logic                     strobe_rise_i,
  input wire logic                     strobe_fall_i,
  input wire logic [LANES-1:0]         write_byte_mask_i,
  input wire logic                     wr_burst_i,
  input wire lpcc_pkg::lpcc_cmd_s      cmd_o,
  input wire lpcc_pkg::lpcc_pwr_e      pwr_state_o,
  input wire logic                     clocks_on_o,
  input wire logic [LANES-1:0]         byte_we_o,
  input wire logic                     wvalid_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  wire run = pwr_state_o inside {LPCC_IDLE, LPCC_ACTIVE};
  wire gate = pins_i.die0_clock_gate;
  wire stb = strobe_rise_i || strobe_fall_i;
  wire [3:0] code = {pins_i.die0_select_n, pins_i.row_strobe_n,
    pins_i.col_strobe_n, pins_i.write_strobe_n};
  a_cmd_taken: assert property (
    run && gate && !code[3] |=> cmd_o.valid) else $error("cmd lost");
  a_cmd_masked: assert property (
    code[3] |=> !cmd_o.valid) else $error("cmd not masked");
  a_cmd_fields: assert property (
    cmd_o.valid |-> cmd_o.code == $past(code) && cmd_o.bank ==
    $past({pins_i.bank_select_hi, pins_i.bank_select_lo}) &&
    cmd_o.auto_precharge_bit == $past(pins_i.addr[AP_BIT]))
    else $error("cmd fields wrong");
  a_act_pd: assert property (
    pwr_state_o == LPCC_ACTIVE && !gate |=> pwr_state_o == LPCC_ACT_PD)
    else $error("no active power-down");
  a_pre_pd: assert property (
    pwr_state_o == LPCC_IDLE && !gate && code != CMD_REF
    |=> pwr_state_o == LPCC_PRE_PD) else $error("no power-down");
  a_self_ref: assert property (
    pwr_state_o == LPCC_IDLE && !gate && code == CMD_REF
    |=> pwr_state_o == LPCC_SELF_REF) else $error("no self refresh");
  a_pd_quiet: assert property (
    !run |=> !cmd_o.valid) else $error("cmd in power-down");
  a_sr_exit: assert property (
    pwr_state_o == LPCC_SELF_REF |-> clocks_on_o == gate)
    else $error("clock gate not followed");
  a_pd_exit: assert property (
    pwr_state_o == LPCC_PRE_PD && gate ##1 gate && code[3]
    |=> pwr_state_o == LPCC_IDLE) else $error("late wake");
  a_mask_we: assert property (
    wr_burst_i && stb && run && gate |=> wvalid_o &&
    byte_we_o == ~$past(write_byte_mask_i)) else $error("mask wrong");
  a_mask_idle: assert property (
    !stb |=> !wvalid_o) else $error("beat without strobe");
  a_sr_leave: assert property (
    pwr_state_o == LPCC_SELF_REF && gate |=> pwr_state_o == LPCC_IDLE)
    else $error("self refresh not left");
  a_act_wake: assert property (
    pwr_state_o == LPCC_ACT_PD && gate ##1 gate && code[3]
    |=> pwr_state_o == LPCC_ACTIVE) else $error("late active wake");
endmodule : lpcc_ctrl_assertions
bind lpcc_ctrl lpcc_ctrl_assertions #(.LANES(LANES)) chk_i (.ref_clk_i,
  .rst_i, .pins_i, .strobe_rise_i, .strobe_fall_i, .write_byte_mask_i,
  .wr_burst_i, .cmd_o, .pwr_state_o, .clocks_on_o, .byte_we_o, .wvalid_o);

// ### verif/lpcc_ctrl_tb.sv
/* Self-checking bench of lpcc_ctrl.
   Assumes the controller model drives every pin but the die1 gate and select, which the bench drives, at 20 MHz. */
`timescale 1ns/10ps
module lpcc_ctrl_tb;
  import lpcc_pkg::*;
  logic ref_clk_i;
  logic rst_i;
  int errors;
  int compares;
  lpcc_cmd_pins_s pins;
  logic rise, fall, burst, clk_on, drv_on, wv;
  logic d1_gate, d1_sel_n;
  logic [15:0] wd, wq;
  logic [1:0] mk, we;
  lpcc_cmd_s cmd;
  lpcc_pwr_e pwr;
  lpcc_mc_model lpcc_mc_model_i (.ref_clk_i, .pins_o(pins), .rise_o(rise),
    .fall_o(fall), .wdata_o(wd), .mask_o(mk), .burst_o(burst));
  lpcc_ctrl lpcc_ctrl_i (.ref_clk_i, .rst_i, .pins_i(pins),
    .die1_clock_gate_i(d1_gate), .die1_select_n_i(d1_sel_n),
    .strobe_rise_i(rise),
    .strobe_fall_i(fall), .wdata_i(wd), .write_byte_mask_i(mk),
    .wr_burst_i(burst), .cmd_o(cmd), .pwr_state_o(pwr),
    .clocks_on_o(clk_on), .drivers_on_o(drv_on), .wdata_o(wq),
    .byte_we_o(we), .wvalid_o(wv));
  initial
  begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task summarize;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  task s_cmds;
    d1_gate = 1'b0;
    d1_sel_n = 1'b0;
    for (int c = 0; c < 16; c++)
    begin
      lpcc_mc_model_i.cmd(1'b1, c[3:0], c[1:0], {3'h0, c[0], 10'h0});
      chk(cmd.valid, !c[3]);
      if (!c[3])
      begin
        chk({cmd.code, cmd.bank, cmd.auto_precharge_bit},
            {c[3:0], c[1:0], c[0]});
        chk(cmd.addr, {3'h0, c[0], 10'h0});
      end
    end
  endtask : s_cmds
  task s_power;
    lpcc_mc_model_i.cmd(1'b1, CMD_PRE, 2'h0, 14'h0400);
    lpcc_mc_model_i.cmd(1'b0, 4'hF, 2'h0, 14'h0000);
    chk({pwr, clk_on, drv_on}, {LPCC_PRE_PD, 2'h0});
    lpcc_mc_model_i.cmd(1'b0, CMD_ACT, 2'h1, 14'h0000);
    chk({cmd.valid, pwr}, {1'b0, LPCC_PRE_PD});
    lpcc_mc_model_i.cmd(1'b1, 4'hF, 2'h0, 14'h0000);
    chk(pwr, LPCC_PRE_PD);
    @(posedge ref_clk_i);
    #1;
    chk(pwr, LPCC_IDLE);
    lpcc_mc_model_i.cmd(1'b1, CMD_ACT, 2'h1, 14'h0000);
    lpcc_mc_model_i.cmd(1'b0, 4'hF, 2'h0, 14'h0000);
    chk({pwr, drv_on}, {LPCC_ACT_PD, 1'b0});
    lpcc_mc_model_i.cmd(1'b1, 4'hF, 2'h0, 14'h0000);
    lpcc_mc_model_i.cmd(1'b1, CMD_PRE, 2'h0, 14'h0400);
    lpcc_mc_model_i.cmd(1'b0, CMD_REF, 2'h0, 14'h0000);
    chk({pwr, clk_on}, {LPCC_SELF_REF, 1'b0});
    @(posedge ref_clk_i);
    #1;
    lpcc_mc_model_i.pins_o.die0_clock_gate = 1'b1;
    #1;
    chk(clk_on, 1'b1);
    @(posedge ref_clk_i);
    #1;
    chk(pwr, LPCC_IDLE);
  endtask : s_power
  task s_mask;
    logic [15:0] d;
    for (int i = 0; i < 4; i++)
    begin
      d = {4{i[3:0]}} ^ 16'h5A3C;
      lpcc_mc_model_i.beat(i[0], i[1], d, i[1:0] ^ 2'h2);
      chk(wv, |i[1:0]);
      if (|i[1:0])
        chk({we, wq}, {~(i[1:0] ^ 2'h2), d});
    end
  endtask : s_mask
  initial
  begin
    errors = 0;
    compares = 0;
    d1_gate = 1'b1;
    d1_sel_n = 1'b1;
    rst_i = 1'b1;
    repeat (16) @(posedge ref_clk_i);
    #1;
    rst_i = 1'b0;
    s_cmds;
    s_power;
    s_mask;
    summarize;
  end
  initial
  begin
    repeat (2000) @(posedge ref_clk_i);
    errors++;
    summarize;
  end
endmodule : lpcc_ctrl_tb

// ### verif/lpcc_mc_model.sv
/* Memory controller model for the command stage.
   Assumes the bench calls its tasks; 16-bit organisation. */
`timescale 1ns/10ps
module lpcc_mc_model
  import lpcc_pkg::*;
(
  input  wire logic                     ref_clk_i,
  output lpcc_pkg::lpcc_cmd_pins_s      pins_o,
  output logic                          rise_o,
  output logic                          fall_o,
  output logic [15:0]                   wdata_o,
  output logic [1:0]                    mask_o,
  output logic                          burst_o
);
  initial
  begin
    pins_o = '1;
    {burst_o, rise_o, fall_o, mask_o} = '0;
    wdata_o = 16'hA5C3;
  end
  task cmd(input logic g, input logic [3:0] c, input logic [1:0] b,
    input logic [13:0] a);
    @(posedge ref_clk_i);
    #1;
    pins_o = {g, c, b, a};
    @(posedge ref_clk_i);
    #1;
    pins_o.die0_select_n = 1'b1;
    pins_o.addr = ~a;
  endtask : cmd
  task beat(input logic r, input logic f, input logic [15:0] d,
    input logic [1:0] m);
    @(posedge ref_clk_i);
    #1;
    {burst_o, rise_o, fall_o} = {1'b1, r, f};
    {wdata_o, mask_o} = {d, m};
    @(posedge ref_clk_i);
    #1;
    {burst_o, rise_o, fall_o, wdata_o, mask_o} = {3'h0, ~d, ~m};
  endtask : beat
endmodule : lpcc_mc_model
